// ==== logic/gpcp_cfg.svh ====
`ifndef GPCP_CFG_SVH
`define GPCP_CFG_SVH
`define GPCP_OFF_CTRL   8'h00
`define GPCP_OFF_CMD    8'h04
`define GPCP_OFF_ARG    8'h08
`define GPCP_OFF_STAT   8'h0c
`define GPCP_OFF_RVAL   8'h10
`define GPCP_OFF_BUS    8'h14
`define GPCP_OFF_IMG0   8'h20
`define GPCP_IMG_WORDS  5
`define GPCP_CMD_OP     0
`define GPCP_CMD_SEL    8
`define GPCP_CMD_IDX    16
`define GPCP_CMD_HAS    24
`define GPCP_BUS_TERM   8
`define GPCP_BUF_FIRST  7'h01
`define GPCP_BUF_MAX    7'h63
`define GPCP_ADDR_RST   5'h08
`define GPCP_TERM_RST   1'b0
`define GPCP_ERR_NONE   8'h00
`define GPCP_ERR_LOCAL  8'h01
`define GPCP_ERR_RANGE  8'h02
`define GPCP_ERR_ZERO   8'h03
`define GPCP_ERR_ARG    8'h04
`define GPCP_ERR_OP     8'h05
`define GPCP_RST_AMPL   16'h03e8
`define GPCP_RST_FREQ   32'h000003e8
`define GPCP_RST_RATE   32'h000003e8
`define GPCP_RST_BURST  16'h0001
`define GPCP_US_PER_S   32'h000f4240
`define GPCP_US_PER_MS  32'h000003e8
`endif

// ==== logic/gpcp_pkg.sv ====
package gpcp_pkg;
	typedef enum logic [1:0] {OUT_OFF = 2'h0, OUT_ON = 2'h1, OUT_FLOAT = 2'h2} gpcp_out_t;
	typedef enum logic [2:0] {
		FN_SINE, FN_SQUARE, FN_TRIANGLE, FN_DC, FN_SINGLE_PULSE_SHAPE, FN_DOUBLE_PULSE_SHAPE
	} gpcp_func_t;
	typedef enum logic [3:0] {
		DS_FREQ, DS_AMPL, DS_OFFS, DS_WIDTH, DS_SWEEP_START, DS_DELAY, DS_SWEEP_STOP,
		DS_BURST_CYCLE_COUNT, DS_RATE
	} gpcp_disp_t;
	typedef enum logic [1:0] {LV_TTL, LV_CMOS, LV_ECL} gpcp_lvl_t;
	typedef enum logic {MD_CONTINUOUS_RUN_SELECT, MD_SINGLE_SHOT_SELECT} gpcp_mode_t;
	typedef enum logic [7:0] {
		OP_AM = 8'h01, OP_FM = 8'h02, OP_OUT = 8'h03, OP_RECALL = 8'h04, OP_STORE = 8'h05,
		OP_STORE_BLK = 8'h06, OP_STORE_ALL = 8'h07, OP_STORE_NEXT = 8'h08, OP_FUNC = 8'h09,
		OP_DC = 8'h0a, OP_AMPL = 8'h0b, OP_DISP = 8'h0c, OP_FREQ = 8'h0d, OP_PERIOD = 8'h0e,
		OP_BURST = 8'h0f, OP_OFFS = 8'h10, OP_LEVELS = 8'h11, OP_RATE = 8'h12, OP_LOCK = 8'h13,
		OP_MODE = 8'h14, OP_AM_Q = 8'h81, OP_FM_Q = 8'h82, OP_OUT_Q = 8'h83, OP_DUMP = 8'h85,
		OP_DUMP_ALL = 8'h87, OP_DUMP_NEXT = 8'h88, OP_FUNC_Q = 8'h89, OP_DC_Q = 8'h8a,
		OP_AMPL_Q = 8'h8b, OP_DISP_Q = 8'h8c, OP_FREQ_Q = 8'h8d, OP_PERIOD_Q = 8'h8e,
		OP_BURST_Q = 8'h8f, OP_OFFS_Q = 8'h90, OP_RATE_Q = 8'h92, OP_LOCK_Q = 8'h93,
		OP_MODE_Q = 8'h94
	} gpcp_op_t;
	typedef struct packed {
		logic               am_en;
		logic               fm_en;
		gpcp_out_t          out;
		gpcp_func_t         func;
		gpcp_disp_t         disp;
		logic               synth_lock_control;
		gpcp_mode_t         mode;
		gpcp_lvl_t          preset_logic_levels;
		logic               period_mode;
		logic [15:0]        ampl;
		logic [15:0]        offs;
		logic [15:0]        dc_level;
		logic [15:0]        burst_cycle_count;
		logic [31:0]        freq;
		logic [31:0]        rate;
	} gpcp_settings_t;
	typedef struct packed {
		logic               psel;
		logic               penable;
		logic               pwrite;
		logic [7:0]         paddr;
		logic [31:0]        pwdata;
	} gpcp_apb_req_t;
	typedef struct packed {
		logic               pready;
		logic [31:0]        prdata;
		logic               pslverr;
	} gpcp_apb_rsp_t;
	typedef struct packed {
		gpcp_settings_t     cur;
		logic               remote;
		logic [4:0]         addr;
		logic               term;
		logic               nv_done;
		logic               nv_we;
		logic [6:0]         nv_s1;
		logic [6:0]         nv_s2;
		logic               err;
		logic [7:0]         ecode;
		logic [7:0]         rcode;
		logic [6:0]         ridx;
		logic [31:0]        rval;
		logic [31:0]        arg;
		logic [159:0]       img;
		logic [6:0]         ptr;
		logic [31:0]        prdata;
		logic               slverr;
	} gpcp_state_t;
endpackage

// ==== logic/gpcp_top.sv ====
`timescale 1ns/1ps
`include "gpcp_cfg.svh"
module gpcp_top (
	input  wire logic                     I_CLK,
	input  wire logic                     I_RESETN,
	input  wire gpcp_pkg::gpcp_apb_req_t  I_APB,
	output      gpcp_pkg::gpcp_apb_rsp_t  O_APB,
	input  wire logic                     I_NV_VALID,
	input  wire logic [4:0]               I_NV_ADDR,
	input  wire logic                     I_NV_TERM,
	output      logic                     O_NV_WE,
	output      logic [4:0]               O_NV_ADDR,
	output      logic                     O_NV_TERM,
	output      gpcp_pkg::gpcp_settings_t O_SETTINGS
);
	localparam gpcp_pkg::gpcp_settings_t PWR_ON = '{
		am_en: 1'b0, fm_en: 1'b0, out: gpcp_pkg::OUT_OFF, func: gpcp_pkg::FN_SINE,
		disp: gpcp_pkg::DS_FREQ, synth_lock_control: 1'b1,
		mode: gpcp_pkg::MD_CONTINUOUS_RUN_SELECT, preset_logic_levels: gpcp_pkg::LV_TTL,
		period_mode: 1'b0, ampl: `GPCP_RST_AMPL, offs: 16'h0000, dc_level: 16'h0000,
		burst_cycle_count: `GPCP_RST_BURST, freq: `GPCP_RST_FREQ, rate: `GPCP_RST_RATE};

	gpcp_pkg::gpcp_state_t    r_reg;
	gpcp_pkg::gpcp_state_t    r_next;
	gpcp_pkg::gpcp_settings_t mem [`GPCP_BUF_FIRST:`GPCP_BUF_MAX];
	logic                     mem_we;
	logic [6:0]               mem_idx;
	gpcp_pkg::gpcp_settings_t mem_d;

	// Buffer 0 is the fixed power-on image and never lives in memory
	function automatic gpcp_pkg::gpcp_settings_t buf_read(input logic [6:0] idx);
		if (idx == 7'h00)
			return PWR_ON;
		return mem[idx];
	endfunction

	// Hit flag and read data for one register address
	function automatic logic [32:0] rd_word(input gpcp_pkg::gpcp_state_t s,
	                                        input logic [7:0] a);
		logic [32:0] v;
		v = {1'b1, 32'h0000_0000};
		case (a)
			`GPCP_OFF_CTRL: v[0] = s.remote;
			`GPCP_OFF_CMD:  v[31:0] = 32'h0000_0000;
			`GPCP_OFF_ARG:  v[31:0] = s.arg;
			`GPCP_OFF_STAT: v[31:0] = {1'b0, s.ridx, s.rcode, s.ecode, 7'h00, s.err};
			`GPCP_OFF_RVAL: v[31:0] = s.rval;
			`GPCP_OFF_BUS:  v[31:0] = {23'h0, s.term, 3'h0, s.addr};
			default: begin
				v[32] = 1'b0;
				for (int i = 0; i < `GPCP_IMG_WORDS; i++) begin
					if (a == `GPCP_OFF_IMG0 + 8'(4 * i)) begin
						v = {1'b1, s.img[i * 32 +: 32]};
					end
				end
			end
		endcase
		return v;
	endfunction

	logic        acc_wr;
	logic [7:0]  op;
	logic [7:0]  sel;
	logic [6:0]  idx;
	logic        has_arg;
	assign acc_wr  = I_APB.psel && I_APB.penable && I_APB.pwrite;
	assign op      = I_APB.pwdata[`GPCP_CMD_OP +: 8];
	assign sel     = I_APB.pwdata[`GPCP_CMD_SEL +: 8];
	assign idx     = I_APB.pwdata[`GPCP_CMD_IDX +: 7];
	assign has_arg = I_APB.pwdata[`GPCP_CMD_HAS];

	always_comb begin
		logic [7:0]  e;
		logic [6:0]  p;
		logic [32:0] rw;
		e = `GPCP_ERR_NONE;
		p = r_reg.ptr;
		rw = rd_word(r_reg, I_APB.paddr);
		r_next = r_reg;
		mem_we = 1'b0;
		mem_idx = `GPCP_BUF_FIRST;
		mem_d = r_reg.cur;
		r_next.nv_we = 1'b0;
		// Two-stage sync of the nonvolatile store's strap lines
		r_next.nv_s1 = {I_NV_VALID, I_NV_ADDR, I_NV_TERM};
		r_next.nv_s2 = r_reg.nv_s1;
		if (!r_reg.nv_done && r_reg.nv_s2[6]) begin
			r_next.addr = r_reg.nv_s2[5:1];
			r_next.term = r_reg.nv_s2[0];
			r_next.nv_done = 1'b1;
		end
		// Read data and error are caught in the setup phase, zero wait access
		if (I_APB.psel && !I_APB.penable) begin
			r_next.prdata = rw[31:0];
			r_next.slverr = !rw[32];
		end
		if (acc_wr) begin
			case (I_APB.paddr)
				`GPCP_OFF_CTRL: r_next.remote = I_APB.pwdata[0];
				`GPCP_OFF_ARG:  r_next.arg = I_APB.pwdata;
				`GPCP_OFF_STAT: begin
					if (I_APB.pwdata[0])
						r_next.err = 1'b0;
				end
				`GPCP_OFF_BUS: begin
					r_next.addr = I_APB.pwdata[4:0];
					r_next.term = I_APB.pwdata[`GPCP_BUS_TERM];
					r_next.nv_done = 1'b1;
					r_next.nv_we = 1'b1;
				end
				`GPCP_OFF_CMD: begin
					// One command set, no variant strap
					if (!r_reg.remote && !op[7]) begin
						e = `GPCP_ERR_LOCAL;
					end else begin
						case (gpcp_pkg::gpcp_op_t'(op))
							gpcp_pkg::OP_AM:   r_next.cur.am_en = sel[0];
							gpcp_pkg::OP_FM:   r_next.cur.fm_en = sel[0];
							gpcp_pkg::OP_AM_Q: r_next.rcode = {7'h00, r_reg.cur.am_en};
							gpcp_pkg::OP_FM_Q: r_next.rcode = {7'h00, r_reg.cur.fm_en};
							gpcp_pkg::OP_OUT: begin
								if (sel > 8'h02)
									e = `GPCP_ERR_ARG;
								else
									r_next.cur.out = gpcp_pkg::gpcp_out_t'(sel[1:0]);
							end
							gpcp_pkg::OP_OUT_Q: r_next.rcode = {6'h00, r_reg.cur.out};
							gpcp_pkg::OP_RECALL: begin
								if (idx > `GPCP_BUF_MAX)
									e = `GPCP_ERR_RANGE;
								else
									r_next.cur = buf_read(idx);
							end
							gpcp_pkg::OP_STORE, gpcp_pkg::OP_STORE_BLK: begin
								if (idx == 7'h00) begin
									e = `GPCP_ERR_ZERO;
								end else if (idx > `GPCP_BUF_MAX) begin
									e = `GPCP_ERR_RANGE;
								end else begin
									mem_we = 1'b1;
									mem_idx = idx;
									if (op == gpcp_pkg::OP_STORE_BLK)
										mem_d = r_reg.img[143:0];
								end
							end
							gpcp_pkg::OP_STORE_ALL, gpcp_pkg::OP_STORE_NEXT: begin
								if (op == gpcp_pkg::OP_STORE_ALL)
									p = `GPCP_BUF_FIRST;
								if (p > `GPCP_BUF_MAX) begin
									e = `GPCP_ERR_RANGE;
								end else begin
									mem_we = 1'b1;
									mem_idx = p;
									mem_d = r_reg.img[143:0];
									r_next.ptr = p + 7'h01;
								end
							end
							gpcp_pkg::OP_DUMP: begin
								if (idx > `GPCP_BUF_MAX) begin
									e = `GPCP_ERR_RANGE;
								end else begin
									r_next.img = {16'h0000, buf_read(idx)};
									r_next.ridx = idx;
								end
							end
							gpcp_pkg::OP_DUMP_ALL, gpcp_pkg::OP_DUMP_NEXT: begin
								if (op == gpcp_pkg::OP_DUMP_ALL)
									p = `GPCP_BUF_FIRST;
								if (p > `GPCP_BUF_MAX) begin
									e = `GPCP_ERR_RANGE;
								end else begin
									r_next.img = {16'h0000, buf_read(p)};
									r_next.ridx = p;
									r_next.ptr = p + 7'h01;
								end
							end
							gpcp_pkg::OP_FUNC: begin
								if (sel > 8'h05)
									e = `GPCP_ERR_ARG;
								else
									r_next.cur.func = gpcp_pkg::gpcp_func_t'(sel[2:0]);
							end
							gpcp_pkg::OP_FUNC_Q: r_next.rcode = {5'h00, r_reg.cur.func};
							gpcp_pkg::OP_DC: begin
								r_next.cur.func = gpcp_pkg::FN_DC;
								if (has_arg)
									r_next.cur.dc_level = r_reg.arg[15:0];
							end
							gpcp_pkg::OP_DC_Q:
								r_next.rval = {{16{r_reg.cur.dc_level[15]}}, r_reg.cur.dc_level};
							gpcp_pkg::OP_AMPL: r_next.cur.ampl = r_reg.arg[15:0];
							gpcp_pkg::OP_AMPL_Q: r_next.rval = {16'h0000, r_reg.cur.ampl};
							gpcp_pkg::OP_DISP: begin
								if (sel > 8'h08)
									e = `GPCP_ERR_ARG;
								else
									r_next.cur.disp = gpcp_pkg::gpcp_disp_t'(sel[3:0]);
							end
							gpcp_pkg::OP_DISP_Q: r_next.rcode = {4'h0, r_reg.cur.disp};
							gpcp_pkg::OP_FREQ, gpcp_pkg::OP_PERIOD: begin
								r_next.cur.freq = r_reg.arg;
								r_next.cur.period_mode = (op == gpcp_pkg::OP_PERIOD);
							end
							gpcp_pkg::OP_FREQ_Q: r_next.rval = r_reg.cur.freq;
							gpcp_pkg::OP_PERIOD_Q:
								r_next.rval = r_reg.cur.period_mode ? r_reg.cur.freq : 32'h0;
							gpcp_pkg::OP_BURST:
								r_next.cur.burst_cycle_count = r_reg.arg[15:0];
							gpcp_pkg::OP_BURST_Q:
								r_next.rval = {16'h0000, r_reg.cur.burst_cycle_count};
							gpcp_pkg::OP_OFFS: r_next.cur.offs = r_reg.arg[15:0];
							gpcp_pkg::OP_OFFS_Q:
								r_next.rval = {{16{r_reg.cur.offs[15]}}, r_reg.cur.offs};
							gpcp_pkg::OP_LEVELS: begin
								if (sel > 8'h02)
									e = `GPCP_ERR_ARG;
								else
									r_next.cur.preset_logic_levels =
										gpcp_pkg::gpcp_lvl_t'(sel[1:0]);
							end
							gpcp_pkg::OP_RATE: begin
								// Units 0 s, 1 ms, 2 us; held in microseconds
								case (sel)
									8'h00: r_next.cur.rate = 32'(r_reg.arg * `GPCP_US_PER_S);
									8'h01: r_next.cur.rate = 32'(r_reg.arg * `GPCP_US_PER_MS);
									8'h02: r_next.cur.rate = r_reg.arg;
									default: e = `GPCP_ERR_ARG;
								endcase
							end
							gpcp_pkg::OP_RATE_Q: r_next.rval = r_reg.cur.rate;
							gpcp_pkg::OP_LOCK: r_next.cur.synth_lock_control = sel[0];
							gpcp_pkg::OP_LOCK_Q:
								r_next.rcode = {7'h00, r_reg.cur.synth_lock_control};
							gpcp_pkg::OP_MODE: begin
								if (sel > 8'h01)
									e = `GPCP_ERR_ARG;
								else
									r_next.cur.mode = gpcp_pkg::gpcp_mode_t'(sel[0]);
							end
							gpcp_pkg::OP_MODE_Q: r_next.rcode = {7'h00, r_reg.cur.mode};
							default: e = `GPCP_ERR_OP;
						endcase
					end
				end
				default: begin
					for (int i = 0; i < `GPCP_IMG_WORDS; i++) begin
						if (I_APB.paddr == `GPCP_OFF_IMG0 + 8'(4 * i))
							r_next.img[i * 32 +: 32] = I_APB.pwdata;
					end
				end
			endcase
		end
		if (e != `GPCP_ERR_NONE) begin
			r_next.err = 1'b1;
			r_next.ecode = e;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			r_reg <= '0;
			r_reg.cur <= PWR_ON;
			r_reg.addr <= `GPCP_ADDR_RST;
			r_reg.term <= `GPCP_TERM_RST;
			r_reg.ptr <= `GPCP_BUF_FIRST;
		end else begin
			r_reg <= r_next;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (mem_we)
			mem[mem_idx] <= mem_d;
	end

	assign O_APB.pready  = 1'b1;
	assign O_APB.prdata  = r_reg.prdata;
	assign O_APB.pslverr = r_reg.slverr && I_APB.psel && I_APB.penable;
	assign O_NV_WE       = r_reg.nv_we;
	assign O_NV_ADDR     = r_reg.addr;
	assign O_NV_TERM     = r_reg.term;
	assign O_SETTINGS    = r_reg.cur;

	logic cmd_wr;
	assign cmd_wr = acc_wr && I_APB.paddr == `GPCP_OFF_CMD;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);

	local_reject_a: assert property (
		cmd_wr && !r_reg.remote && !op[7] |=> r_reg.err && r_reg.ecode == `GPCP_ERR_LOCAL
		##1 (r_reg.cur == $past(r_reg.cur, 2))) else $error("local setting not rejected");
	local_query_a: assert property (
		cmd_wr && !r_reg.remote && op == gpcp_pkg::OP_AM_Q
		|=> r_reg.rcode == {7'h00, $past(r_reg.cur.am_en)}) else $error("local query lost");
	am_apply_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_AM
		|=> O_SETTINGS.am_en == $past(sel[0])) else $error("am enable not applied");
	out_float_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_OUT && sel == 8'h02
		|=> O_SETTINGS.out == gpcp_pkg::OUT_FLOAT) else $error("float not applied");
	store_zero_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_STORE && idx == 7'h00
		|-> !mem_we ##1 r_reg.err && r_reg.ecode == `GPCP_ERR_ZERO) else $error("buffer 0 written");
	recall_range_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_RECALL && idx > `GPCP_BUF_MAX
		|=> $stable(r_reg.cur) && r_reg.ecode == `GPCP_ERR_RANGE) else $error("bad recall accepted");
	recall_zero_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_RECALL && idx == 7'h00
		|=> O_SETTINGS == PWR_ON) else $error("recall 0 not power-on");
	dump_first_a: assert property (
		cmd_wr && op == gpcp_pkg::OP_DUMP_ALL
		|=> r_reg.ridx == `GPCP_BUF_FIRST && r_reg.ptr == 7'h02) else $error("dump-all start wrong");
	period_off_a: assert property (
		cmd_wr && op == gpcp_pkg::OP_PERIOD_Q && !r_reg.cur.period_mode
		|=> r_reg.rval == 32'h0) else $error("period query not zero");
	nv_default_a: assert property (@(posedge I_CLK) disable iff (1'b0)
		!I_RESETN |=> O_NV_ADDR == `GPCP_ADDR_RST && O_NV_TERM == `GPCP_TERM_RST)
		else $error("bus defaults wrong");
	dc_select_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_DC && !has_arg
		|=> O_SETTINGS.func == gpcp_pkg::FN_DC && $stable(O_SETTINGS.dc_level))
		else $error("dc select changed the level");
	func_reject_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_FUNC && sel > 8'h05
		|=> $stable(O_SETTINGS.func) && r_reg.ecode == `GPCP_ERR_ARG)
		else $error("bad waveform accepted");
	levels_reject_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_LEVELS && sel > 8'h02
		|=> $stable(O_SETTINGS.preset_logic_levels) && r_reg.ecode == `GPCP_ERR_ARG)
		else $error("bad level family accepted");
	rate_ms_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_RATE && sel == 8'h01
		|=> O_SETTINGS.rate == 32'($past(r_reg.arg) * `GPCP_US_PER_MS))
		else $error("rate in milliseconds wrong");
	lock_apply_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_LOCK
		|=> O_SETTINGS.synth_lock_control == $past(sel[0]))
		else $error("frequency lock not applied");
	mode_apply_a: assert property (
		cmd_wr && r_reg.remote && op == gpcp_pkg::OP_MODE && sel < 8'h02
		|=> O_SETTINGS.mode == gpcp_pkg::gpcp_mode_t'($past(sel[0])))
		else $error("run mode not applied");

	store_cov_c: cover property (cmd_wr && r_reg.remote && op == gpcp_pkg::OP_STORE
		##[1:20] cmd_wr && op == gpcp_pkg::OP_RECALL);
	local_cov_c: cover property (cmd_wr && !r_reg.remote ##1 r_reg.err);
	dump_cov_c: cover property (cmd_wr && op == gpcp_pkg::OP_DUMP_ALL
		##[1:20] cmd_wr && op == gpcp_pkg::OP_DUMP_NEXT);
	float_cov_c: cover property (cmd_wr && r_reg.remote
		&& op == gpcp_pkg::OP_OUT && sel == 8'h02);
	period_cov_c: cover property (cmd_wr && op == gpcp_pkg::OP_PERIOD
		##[1:20] cmd_wr && op == gpcp_pkg::OP_PERIOD_Q);
endmodule

// ==== tb/gpcp_nv_model.sv ====
`timescale 1ns/1ps
module gpcp_nv_model #(
	parameter int         DELAY = 10,
	parameter logic [4:0] ADDR0 = 5'h08,
	parameter logic       TERM0 = 1'b0
) (
	input  wire logic       i_clk,
	input  wire logic       i_we,
	input  wire logic [4:0] i_addr,
	input  wire logic       i_term,
	output      logic       o_valid,
	output      logic [4:0] o_addr,
	output      logic       o_term,
	output      int         o_writes
);
	int cnt;
	initial begin
		cnt      = 0;
		o_valid  = 1'b0;
		o_addr   = ADDR0;
		o_term   = TERM0;
		o_writes = 0;
	end
	// Contents become readable some cycles after power-up
	always @(posedge i_clk) begin
		cnt <= cnt + 1;
		if (cnt == DELAY)
			o_valid <= 1'b1;
		if (i_we) begin
			o_addr   <= i_addr;
			o_term   <= i_term;
			o_writes <= o_writes + 1;
		end
	end
endmodule

// ==== tb/gpcp_tb_top.sv ====
`timescale 1ns/1ps
`include "gpcp_cfg.svh"
module gpcp_tb_top;
	typedef struct {
		string       nm;
		logic [31:0] e;
		logic [31:0] m;
		logic        se;
	} gpcp_note_t;
	logic                     clk;
	logic                     rst_n;
	gpcp_pkg::gpcp_apb_req_t  req;
	gpcp_pkg::gpcp_apb_rsp_t  rsp;
	gpcp_pkg::gpcp_settings_t sett, es, es0, s5, im;
	logic                     nv_valid, nv_term, nv_we, dut_term;
	logic [4:0]               nv_addr, dut_addr;
	int                       nv_writes, seed, failures, comparisons;
	logic [31:0]              r;
	logic [159:0]             img;
	logic [31:0]              mul [3];
	gpcp_note_t               notes [$];
	gpcp_note_t               nt;

	gpcp_top u_gpcp_top (
		.I_CLK      (clk),
		.I_RESETN   (rst_n),
		.I_APB      (req),
		.O_APB      (rsp),
		.I_NV_VALID (nv_valid),
		.I_NV_ADDR  (nv_addr),
		.I_NV_TERM  (nv_term),
		.O_NV_WE    (nv_we),
		.O_NV_ADDR  (dut_addr),
		.O_NV_TERM  (dut_term),
		.O_SETTINGS (sett)
	);
	gpcp_nv_model u_gpcp_nv_model (
		.i_clk    (clk),
		.i_we     (nv_we),
		.i_addr   (dut_addr),
		.i_term   (dut_term),
		.o_valid  (nv_valid),
		.o_addr   (nv_addr),
		.o_term   (nv_term),
		.o_writes (nv_writes)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [143:0] e, input logic [143:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Read data is judged where the transfer completes
	always @(posedge clk) begin
		if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite && notes.size() > 0) begin
			nt = notes.pop_front();
			chk(nt.nm, 144'(nt.e & nt.m), 144'(rsp.prdata & nt.m));
			chk("pslverr", 144'(nt.se), 144'(rsp.pslverr));
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e,
		input logic [31:0] m, input logic se = 1'b0);
		notes.push_back('{nm, e, m, se});
		apb(1'b0, a, 32'h00000000);
	endtask

	task automatic cmd(input logic [7:0] op, input logic [7:0] s, input logic [6:0] ix,
		input logic h);
		apb(1'b1, `GPCP_OFF_CMD, {7'h00, h, 1'b0, ix, s, op});
		@(posedge clk);
		#1;
		chk("settings", 144'(es), 144'(sett));
	endtask

	task automatic ers(input logic [7:0] c);
		rd(`GPCP_OFF_STAT, "stat", {16'h0000, c, 7'h00, c != 8'h00},
			(c != 8'h00) ? 32'h0000ff01 : 32'h00000001);
		if (c != 8'h00)
			apb(1'b1, `GPCP_OFF_STAT, 32'h00000001);
	endtask

	task automatic sq(input logic [7:0] op, input logic [7:0] q, input logic [7:0] s);
		cmd(op, s, 7'h00, 1'b0);
		cmd(q, 8'h00, 7'h00, 1'b0);
		rd(`GPCP_OFF_STAT, "rcode", {8'h00, s, 16'h0000}, 32'h00ff0000);
	endtask

	task automatic num(input logic [7:0] op, input logic [7:0] q, input logic [7:0] s,
		input logic [31:0] v, input logic [31:0] e);
		apb(1'b1, `GPCP_OFF_ARG, v);
		cmd(op, s, 7'h00, 1'b1);
		cmd(q, 8'h00, 7'h00, 1'b0);
		rd(`GPCP_OFF_RVAL, "rval", e, 32'hffffffff);
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		conclude();
	end

	initial begin
		seed = 32'h94c9;
		failures = 0;
		comparisons = 0;
		rst_n = 1'b0;
		req = '0;
		mul = '{`GPCP_US_PER_S, `GPCP_US_PER_MS, 32'h00000001};
		es = '0;
		es.synth_lock_control = 1'b1;
		es.ampl = `GPCP_RST_AMPL;
		es.freq = `GPCP_RST_FREQ;
		es.rate = `GPCP_RST_RATE;
		es.burst_cycle_count = `GPCP_RST_BURST;
		es0 = es;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk("power_on", 144'(es0), 144'(sett));
		chk("bus_addr", 144'(`GPCP_ADDR_RST), 144'(dut_addr));
		chk("bus_term", 144'(`GPCP_TERM_RST), 144'(dut_term));
		$display("test reset done");

		r = 32'($random(seed)) & 32'h00007fff;
		num(gpcp_pkg::OP_AMPL, gpcp_pkg::OP_AMPL_Q, 8'h00, r, 32'(`GPCP_RST_AMPL));
		ers(`GPCP_ERR_LOCAL);
		cmd(gpcp_pkg::OP_FUNC, 8'h01, 7'h00, 1'b0);
		ers(`GPCP_ERR_LOCAL);
		cmd(gpcp_pkg::OP_AM_Q, 8'h00, 7'h00, 1'b0);
		rd(`GPCP_OFF_STAT, "rcode", 32'h00000000, 32'h00ff0000);
		apb(1'b1, `GPCP_OFF_CTRL, 32'h00000001);
		rd(`GPCP_OFF_CTRL, "remote", 32'h00000001, 32'h00000001);
		$display("test local done");

		for (int i = 0; i < 9; i++) begin
			if (i < 2) begin
				es.am_en = i[0];
				sq(gpcp_pkg::OP_AM, gpcp_pkg::OP_AM_Q, 8'(i));
				es.fm_en = i[0];
				sq(gpcp_pkg::OP_FM, gpcp_pkg::OP_FM_Q, 8'(i));
				es.synth_lock_control = i[0];
				sq(gpcp_pkg::OP_LOCK, gpcp_pkg::OP_LOCK_Q, 8'(i));
				es.mode = gpcp_pkg::gpcp_mode_t'(i[0]);
				sq(gpcp_pkg::OP_MODE, gpcp_pkg::OP_MODE_Q, 8'(i));
			end
			if (i < 3) begin
				es.out = gpcp_pkg::gpcp_out_t'(i[1:0]);
				sq(gpcp_pkg::OP_OUT, gpcp_pkg::OP_OUT_Q, 8'(i));
				es.preset_logic_levels = gpcp_pkg::gpcp_lvl_t'(i[1:0]);
				cmd(gpcp_pkg::OP_LEVELS, 8'(i), 7'h00, 1'b0);
			end
			if (i < 6) begin
				es.func = gpcp_pkg::gpcp_func_t'(i[2:0]);
				sq(gpcp_pkg::OP_FUNC, gpcp_pkg::OP_FUNC_Q, 8'(i));
			end
			es.disp = gpcp_pkg::gpcp_disp_t'(i[3:0]);
			sq(gpcp_pkg::OP_DISP, gpcp_pkg::OP_DISP_Q, 8'(i));
		end
		cmd(gpcp_pkg::OP_OUT, 8'h03, 7'h00, 1'b0);
		ers(`GPCP_ERR_ARG);
		cmd(gpcp_pkg::OP_LEVELS, 8'h03, 7'h00, 1'b0);
		ers(`GPCP_ERR_ARG);
		cmd(gpcp_pkg::OP_DISP, 8'h09, 7'h00, 1'b0);
		ers(`GPCP_ERR_ARG);
		cmd(gpcp_pkg::OP_FUNC, 8'h06, 7'h00, 1'b0);
		ers(`GPCP_ERR_ARG);
		cmd(8'h7f, 8'h00, 7'h00, 1'b0);
		ers(`GPCP_ERR_OP);
		$display("test modes done");

		r = 32'($random(seed)) & 32'h00007fff;
		es.ampl = r[15:0];
		num(gpcp_pkg::OP_AMPL, gpcp_pkg::OP_AMPL_Q, 8'h00, r, r);
		es.burst_cycle_count = r[15:0];
		num(gpcp_pkg::OP_BURST, gpcp_pkg::OP_BURST_Q, 8'h00, r, r);
		es.offs = r[15:0];
		num(gpcp_pkg::OP_OFFS, gpcp_pkg::OP_OFFS_Q, 8'h00, r, r);
		es.offs = 16'h0000;
		num(gpcp_pkg::OP_OFFS, gpcp_pkg::OP_OFFS_Q, 8'h00, 32'h0, 32'h0);
		es.func = gpcp_pkg::FN_DC;
		es.dc_level = r[15:0];
		num(gpcp_pkg::OP_DC, gpcp_pkg::OP_DC_Q, 8'h00, r, r);
		es.func = gpcp_pkg::FN_SINE;
		cmd(gpcp_pkg::OP_FUNC, 8'h00, 7'h00, 1'b0);
		apb(1'b1, `GPCP_OFF_ARG, 32'h00000011);
		es.func = gpcp_pkg::FN_DC;
		cmd(gpcp_pkg::OP_DC, 8'h00, 7'h00, 1'b0);
		r = 32'($random(seed));
		es.freq = r;
		num(gpcp_pkg::OP_FREQ, gpcp_pkg::OP_PERIOD_Q, 8'h00, r, 32'h0);
		es.freq = r ^ 32'h00ff00ff;
		es.period_mode = 1'b1;
		num(gpcp_pkg::OP_PERIOD, gpcp_pkg::OP_PERIOD_Q, 8'h00, es.freq, es.freq);
		cmd(gpcp_pkg::OP_FREQ_Q, 8'h00, 7'h00, 1'b0);
		rd(`GPCP_OFF_RVAL, "freq", es.freq, 32'hffffffff);
		for (int i = 0; i < 3; i++) begin
			es.rate = mul[i] * 32'h00000003;
			num(gpcp_pkg::OP_RATE, gpcp_pkg::OP_RATE_Q, 8'(i), 32'h3, es.rate);
		end
		$display("test values done");

		s5 = es;
		cmd(gpcp_pkg::OP_STORE, 8'h00, 7'h05, 1'b0);
		es.ampl = 16'h0042;
		num(gpcp_pkg::OP_AMPL, gpcp_pkg::OP_AMPL_Q, 8'h00, 32'h42, 32'h42);
		cmd(gpcp_pkg::OP_STORE, 8'h00, 7'h00, 1'b0);
		ers(`GPCP_ERR_ZERO);
		cmd(gpcp_pkg::OP_STORE, 8'h00, 7'h64, 1'b0);
		ers(`GPCP_ERR_RANGE);
		cmd(gpcp_pkg::OP_RECALL, 8'h00, 7'h64, 1'b0);
		ers(`GPCP_ERR_RANGE);
		es = s5;
		cmd(gpcp_pkg::OP_RECALL, 8'h00, 7'h05, 1'b0);
		cmd(gpcp_pkg::OP_DUMP, 8'h00, 7'h05, 1'b0);
		rd(`GPCP_OFF_STAT, "ridx", 32'h05000000, 32'h7f000000);
		rd(`GPCP_OFF_IMG0, "img0", s5.rate, 32'hffffffff);
		es = es0;
		cmd(gpcp_pkg::OP_RECALL, 8'h00, 7'h00, 1'b0);
		im = es0;
		im.ampl = r[15:0];
		im.func = gpcp_pkg::FN_SQUARE;
		im.out = gpcp_pkg::OUT_FLOAT;
		img = {16'h0000, im};
		for (int k = 0; k < 5; k++)
			apb(1'b1, 8'(`GPCP_OFF_IMG0 + 4 * k), img[32 * k +: 32]);
		cmd(gpcp_pkg::OP_STORE_BLK, 8'h00, 7'h03, 1'b0);
		cmd(gpcp_pkg::OP_STORE_ALL, 8'h00, 7'h00, 1'b0);
		cmd(gpcp_pkg::OP_STORE_NEXT, 8'h00, 7'h00, 1'b0);
		es = im;
		cmd(gpcp_pkg::OP_RECALL, 8'h00, 7'h01, 1'b0);
		cmd(gpcp_pkg::OP_RECALL, 8'h00, 7'h02, 1'b0);
		cmd(gpcp_pkg::OP_RECALL, 8'h00, 7'h03, 1'b0);
		cmd(gpcp_pkg::OP_DUMP_ALL, 8'h00, 7'h00, 1'b0);
		rd(`GPCP_OFF_STAT, "ridx", 32'h01000000, 32'h7f000000);
		cmd(gpcp_pkg::OP_DUMP_NEXT, 8'h00, 7'h00, 1'b0);
		rd(`GPCP_OFF_STAT, "ridx", 32'h02000000, 32'h7f000000);
		$display("test storage done");

		rd(`GPCP_OFF_STAT, "err_clear", 32'h00000000, 32'h00000001);
		rd(8'hfc, "unmapped", 32'h0, 32'hffffffff, 1'b1);
		rd(`GPCP_OFF_CMD, "cmd_read", 32'h0, 32'hffffffff);
		apb(1'b1, `GPCP_OFF_BUS, 32'h0000010b);
		repeat (4) @(posedge clk);
		#1;
		chk("nv_writes", 144'(1), 144'(nv_writes));
		chk("nv_addr", 144'(5'h0b), 144'(nv_addr));
		chk("nv_term", 144'(1'b1), 144'(nv_term));
		rd(`GPCP_OFF_BUS, "bus", 32'h0000010b, 32'h0000011f);
		$display("test bus done");
		conclude();
	end
endmodule
